// ==== cfc_fault_confine.sv ====
// Purpose: error detection, fault confinement, overload and sleep control
// Assumes: bit_i and evt_i come from logic on mclk; canrx is a raw pin
// Notes:   error and overload requests start the frame in the next bit
`timescale 1ns/1ps
`default_nettype none
module cfc_fault_confine (
	input  wire logic              mclk,
	input  wire logic              nrst,
	input  wire logic              ce,
	input  wire logic              canrx,
	input  wire cfc_pkg::cfc_bit_t bit_i,
	input  wire cfc_pkg::cfc_evt_t evt_i,
	input  wire logic [3:0]        addr,
	input  wire logic [31:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic [31:0]            rdata,
	output logic                   err_frame_req,
	output logic                   err_flag_passive,
	output logic                   ovl_frame_req,
	output logic                   tx_suspend,
	output logic                   tx_enable,
	output logic                   rx_enable,
	output logic                   mbox_enable,
	output logic                   bus_drive_en,
	output logic [14:0]            crc_value,
	output logic                   irq
);

	logic                  rst_q1;
	logic                  rst_n;
	logic                  rx_q1;
	logic                  rx_s;
	logic                  en_r;
	logic                  lpm_r;
	logic                  ovl_en_r;
	logic [31:0]           mask_r;
	logic [8:0]            tec_r;
	logic [8:0]            tec_nxt;
	logic [7:0]            rec_r;
	logic [7:0]            rec_nxt;
	logic [cfc_pkg::ERR_N-1:0] flags_r;
	logic [14:0]           crc_r;
	logic [2:0]            scnt_r;
	logic                  prev_r;
	logic [3:0]            run_r;
	logic [7:0]            runs_r;
	logic                  sleep_r;
	logic                  wake_r;
	logic                  err_r;
	logic                  ovl_r;
	logic                  susp_r;
	logic [31:0]           rdata_r;
	logic [31:0]           status_w;
	logic [31:0]           rd_mux;
	cfc_pkg::cfc_st_t      st_r;
	cfc_pkg::cfc_st_t      st_nxt;
	cfc_pkg::cfc_fld_t     fld;

	// reset release through two flops
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_q1 <= 1'b1;
			rx_s  <= 1'b1;
		end else if (ce) begin
			rx_q1 <= canrx;
			rx_s  <= rx_q1;
		end
	end

	// register decode
	assign fld = bit_i.fld;
	wire wr_mode = wr & (addr == cfc_pkg::OFF_MODE);
	wire wr_mask = wr & (addr == cfc_pkg::OFF_MASK);
	wire st_rd   = rd & (addr == cfc_pkg::OFF_STATUS);
	wire en_rise = wr_mode & wdata[cfc_pkg::MD_EN] & ~en_r;

	// live state from the counters
	wire [8:0] rec9      = {1'b0, rec_r};
	wire bus_off_w  = tec_r > cfc_pkg::BUS_OFF_STATUS_LIMIT;
	wire passive_w  = bus_off_w | (tec_r > cfc_pkg::PASS_LIMIT)
	                | (rec9 > cfc_pkg::PASS_LIMIT);
	wire active_w   = ~passive_w;
	wire warn_w     = active_w & ((tec_r > cfc_pkg::WARN_LIMIT)
	                | (rec9 > cfc_pkg::WARN_LIMIT));

	wire awake_w    = (st_r == cfc_pkg::S_RUN) | (st_r == cfc_pkg::S_LPWAIT);
	wire node_on    = en_r & awake_w & ~bus_off_w & ~sleep_r;
	wire tk         = bit_i.tick & node_on;
	wire dom        = ~rx_s;

	// per-bit checks
	wire in_crc   = (fld >= cfc_pkg::FLD_SOF) & (fld <= cfc_pkg::FLD_DATA);
	wire in_stuff = (fld >= cfc_pkg::FLD_SOF) & (fld <= cfc_pkg::FLD_CRC);
	wire in_frame = (fld != cfc_pkg::FLD_IDLE) & (fld < cfc_pkg::FLD_INTER);
	wire same     = rx_s == prev_r;
	wire is_sof   = fld == cfc_pkg::FLD_SOF;
	wire crc_feed = (in_crc | (fld == cfc_pkg::FLD_CRC)) & ~bit_i.stuff_bit;
	wire [14:0] crc_base = is_sof ? 15'h0000 : crc_r;
	wire [14:0] crc_step = {crc_base[13:0], 1'b0}
	                     ^ ({15{rx_s ^ crc_base[14]}} & cfc_pkg::CRC_POLY);
	wire rx_eof_last = (fld == cfc_pkg::FLD_EOF) & bit_i.last & ~bit_i.tx_act;

	wire e_stuff = in_stuff & ~is_sof & same
	             & (scnt_r == cfc_pkg::STUFF_LIMIT - 3'h1);
	wire e_bit   = bit_i.tx_act & in_frame & (rx_s != bit_i.tx_bit)
	             & (fld != cfc_pkg::FLD_ACK_SLOT)
	             & ((fld != cfc_pkg::FLD_ARB) | ~bit_i.tx_bit);
	wire e_form  = dom & ((fld == cfc_pkg::FLD_CRC_DEL)
	             | (fld == cfc_pkg::FLD_ACK_DEL)
	             | ((fld == cfc_pkg::FLD_EOF) & ~rx_eof_last));
	wire e_ack   = bit_i.tx_act & (fld == cfc_pkg::FLD_ACK_SLOT) & rx_s;
	wire e_crc   = (fld == cfc_pkg::FLD_CRC) & bit_i.last & ~bit_i.stuff_bit
	             & (crc_step != 15'h0000);

	wire [cfc_pkg::ERR_N-1:0] errv =
		{e_bit, e_stuff, e_crc, e_form, e_ack} & {cfc_pkg::ERR_N{tk}};
	wire any_err = |errv;

	wire ovl_react = tk & dom & (((fld == cfc_pkg::FLD_INTER)
	               & (bit_i.idx < cfc_pkg::INTER_REACT)) | rx_eof_last
	               | (((fld == cfc_pkg::FLD_ERR_DEL)
	               | (fld == cfc_pkg::FLD_OVL_DEL)) & bit_i.last));
	wire ovl_reqst = evt_i.delivered & ovl_en_r & node_on;

	// recessive run detector
	wire rtk       = bit_i.tick & en_r & (st_r != cfc_pkg::S_SLEEP);
	wire run_hit   = run_r == cfc_pkg::RUN_LEN - 4'h1;
	wire rec11     = rtk & rx_s & run_hit;
	wire bus_off_status_done = rec11 & bus_off_w
	               & (runs_r == cfc_pkg::BUS_OFF_STATUS_RUNS - 8'h01);
	wire frozen    = sleep_r | ~en_r;
	// recessive runs count only from bus-off entry onwards
	wire bus_off_status_entry = ~bus_off_w & (tec_nxt > cfc_pkg::BUS_OFF_STATUS_LIMIT);

	always_comb begin
		tec_nxt = tec_r;
		rec_nxt = rec_r;
		if (en_rise | bus_off_status_done) begin
			tec_nxt = 9'h000;
			rec_nxt = 8'h00;
		end else if (!frozen) begin
			if (any_err) begin
				if (bit_i.tx_act) begin
					if (!bus_off_w)
						tec_nxt = tec_r + cfc_pkg::TEC_INC;
				end else if (rec_r != 8'hff) begin
					rec_nxt = rec_r + cfc_pkg::REC_INC;
				end
			end else begin
				if (evt_i.tx_ok && tec_r != 9'h000 && !bus_off_w)
					tec_nxt = tec_r - 9'h001;
				if (evt_i.rx_ok && rec_r != 8'h00)
					rec_nxt = rec_r - 8'h01;
			end
		end
	end

	// wake and sleep sequencing
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			cfc_pkg::S_DIS:    if (en_r) st_nxt = cfc_pkg::S_SYNC;
			cfc_pkg::S_SYNC:   if (rec11) st_nxt = cfc_pkg::S_RUN;
			cfc_pkg::S_RUN:    if (lpm_r) st_nxt = cfc_pkg::S_LPWAIT;
			cfc_pkg::S_LPWAIT: begin
				if (!lpm_r)
					st_nxt = cfc_pkg::S_RUN;
				else if (!evt_i.tx_pending && fld == cfc_pkg::FLD_IDLE)
					st_nxt = cfc_pkg::S_SLEEP;
			end
			cfc_pkg::S_SLEEP:  if (!lpm_r) st_nxt = cfc_pkg::S_SYNC;
			default:           st_nxt = cfc_pkg::S_DIS;
		endcase
		if (en_rise)
			st_nxt = cfc_pkg::S_SYNC;
		else if (!en_r)
			st_nxt = cfc_pkg::S_DIS;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_r    <= cfc_pkg::S_DIS;
			sleep_r <= 1'b0;
			wake_r  <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
			if (st_r == cfc_pkg::S_SYNC && st_nxt == cfc_pkg::S_RUN) begin
				wake_r  <= 1'b1;
				sleep_r <= 1'b0;
			end else if (st_nxt == cfc_pkg::S_SLEEP && st_r != cfc_pkg::S_SLEEP) begin
				sleep_r <= 1'b1;
				wake_r  <= 1'b0;
			end
		end
	end

	// software registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			en_r     <= 1'b0;
			lpm_r    <= 1'b0;
			ovl_en_r <= 1'b0;
			mask_r   <= 32'h00000000;
		end else if (ce) begin
			if (wr_mode) begin
				en_r     <= wdata[cfc_pkg::MD_EN];
				lpm_r    <= wdata[cfc_pkg::MD_LPM];
				ovl_en_r <= wdata[cfc_pkg::MD_OVL];
			end
			if (wr_mask)
				mask_r <= wdata & cfc_pkg::MASK_USED;
		end
	end

	// counters, sticky flags, bit history
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tec_r   <= 9'h000;
			rec_r   <= 8'h00;
			flags_r <= '0;
			crc_r   <= 15'h0000;
			scnt_r  <= 3'h0;
			prev_r  <= 1'b1;
		end else if (ce) begin
			tec_r <= tec_nxt;
			rec_r <= rec_nxt;
			if (en_rise)
				flags_r <= '0;
			else
				flags_r <= (flags_r & ~{cfc_pkg::ERR_N{st_rd}}) | errv;
			if (en_rise) begin
				crc_r  <= 15'h0000;
				scnt_r <= 3'h0;
			end else if (tk) begin
				if (crc_feed)
					crc_r <= crc_step;
				if (in_stuff) begin
					prev_r <= rx_s;
					scnt_r <= (is_sof | ~same) ? 3'h1 : scnt_r + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			run_r  <= 4'h0;
			runs_r <= 8'h00;
		end else if (ce) begin
			if (!en_r || st_r == cfc_pkg::S_SLEEP || en_rise || bus_off_status_entry)
				run_r <= 4'h0;
			else if (rtk)
				run_r <= (dom | run_hit) ? 4'h0 : run_r + 4'h1;
			if (!bus_off_w || en_rise)
				runs_r <= 8'h00;
			else if (rec11)
				runs_r <= runs_r + 8'h01;
		end
	end

	// requests to the frame sequencer, and registered read data
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			err_r   <= 1'b0;
			ovl_r   <= 1'b0;
			susp_r  <= 1'b0;
			rdata_r <= 32'h00000000;
		end else if (ce) begin
			err_r   <= any_err;
			ovl_r   <= ovl_react | ovl_reqst;
			susp_r  <= evt_i.tx_ok & passive_w & node_on;
			rdata_r <= rd ? rd_mux : 32'h00000000;
		end
	end

	always_comb begin
		status_w = 32'h00000000;
		status_w[cfc_pkg::ST_ACTIVE]  = active_w;
		status_w[cfc_pkg::ST_WARN]    = warn_w;
		status_w[cfc_pkg::ST_PASSIVE] = passive_w;
		status_w[cfc_pkg::ST_BUS_OFF_STATUS]    = bus_off_w;
		status_w[cfc_pkg::ST_SLEEP]   = sleep_r;
		status_w[cfc_pkg::ST_WAKE]    = wake_r;
		status_w[cfc_pkg::ST_ERR_LSB +: cfc_pkg::ERR_N] = flags_r;
	end

	wire [31:0] mode_w = {29'h0, ovl_en_r, lpm_r, en_r};
	wire [31:0] ecr_w  = {7'h00, tec_r, 8'h00, rec_r};
	assign rd_mux = (addr == cfc_pkg::OFF_MODE)   ? mode_w   :
	                (addr == cfc_pkg::OFF_MASK)   ? mask_r   :
	                (addr == cfc_pkg::OFF_STATUS) ? status_w :
	                (addr == cfc_pkg::OFF_ERRCNT) ? ecr_w    : 32'h00000000;

	assign rdata            = rdata_r;
	assign err_frame_req    = err_r;
	assign err_flag_passive = passive_w;
	assign ovl_frame_req    = ovl_r;
	assign tx_suspend       = susp_r;
	assign tx_enable        = node_on;
	assign rx_enable        = node_on;
	assign mbox_enable      = en_r & ~sleep_r;
	assign bus_drive_en     = node_on;
	assign crc_value        = crc_r;
	assign irq              = |(status_w & mask_r);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_stuff_sixth: assert property (ce && tk && e_stuff |=> err_frame_req
		&& flags_r[cfc_pkg::ERR_STUFF]) else $error("stuff error lost");
	a_bit_error: assert property (ce && tk && bit_i.tx_act && in_frame
		&& fld != cfc_pkg::FLD_ARB && fld != cfc_pkg::FLD_ACK_SLOT
		&& rx_s != bit_i.tx_bit |=> err_frame_req
		&& flags_r[cfc_pkg::ERR_BIT]) else $error("bit error lost");
	a_form_error: assert property (ce && tk && dom
		&& (fld == cfc_pkg::FLD_CRC_DEL || fld == cfc_pkg::FLD_ACK_DEL) |=> err_frame_req
		&& flags_r[cfc_pkg::ERR_FORM]) else $error("form error lost");
	a_ack_missing: assert property (ce && tk && bit_i.tx_act && rx_s
		&& fld == cfc_pkg::FLD_ACK_SLOT |=> err_frame_req
		&& flags_r[cfc_pkg::ERR_ACK]) else $error("ack error lost");
	a_tec_step: assert property (ce && !en_rise && !frozen && any_err
		&& bit_i.tx_act && !bus_off_w |=> tec_r == $past(tec_r)
		+ cfc_pkg::TEC_INC) else $error("tec step wrong");
	a_state_code: assert property (bus_off_w |-> passive_w && !active_w
		&& status_w[cfc_pkg::ST_BUS_OFF_STATUS]) else $error("bus-off pattern");
	a_warn_irq: assert property (warn_w && mask_r[cfc_pkg::ST_WARN]
		|-> irq && !passive_w) else $error("warn irq missing");
	a_bus_off_status_exit: assert property (ce && bus_off_status_done && !en_rise |=> tec_r == 9'h000
		&& !bus_off_w) else $error("bus-off exit wrong");
	a_ovl_no_count: assert property (ce && ovl_react && !any_err && !en_rise
		&& !evt_i.tx_ok && !evt_i.rx_ok |=> ovl_frame_req
		&& $stable(tec_r) && $stable(rec_r)) else $error("ovl counted");
	a_sleep_excl: assert property (!(sleep_r && wake_r))
		else $error("sleep and wake both set");
	a_sleep_entry: assert property (ce && st_r == cfc_pkg::S_LPWAIT && lpm_r
		&& evt_i.tx_pending && !en_rise && en_r |=> !sleep_r || $past(sleep_r))
		else $error("sleep before transmits done");
	a_bus_silent: assert property (bus_off_w |-> !tx_enable && !bus_drive_en
		&& (!err_frame_req || $rose(bus_off_w))) else $error("bus-off drives bus");

	c_bus_off: cover property ($rose(bus_off_w));
	c_sleep:   cover property ($rose(sleep_r));
	c_wake:    cover property ($rose(wake_r));
	c_ovl:     cover property (ovl_frame_req);

endmodule : cfc_fault_confine
`default_nettype wire

// ==== cfc_pkg.sv ====
// Purpose: shared types and constants of the can fault confinement block
// Assumes: a frame sequencer on mclk supplies per-bit field information
// Notes:   offsets are byte addresses on the plain register port
package cfc_pkg;

	typedef enum logic [3:0] {
		FLD_IDLE     = 4'h0,
		FLD_SOF      = 4'h1,
		FLD_ARB      = 4'h2,
		FLD_CTRL     = 4'h3,
		FLD_DATA     = 4'h4,
		FLD_CRC      = 4'h5,
		FLD_CRC_DEL  = 4'h6,
		FLD_ACK_SLOT = 4'h7,
		FLD_ACK_DEL  = 4'h8,
		FLD_EOF      = 4'h9,
		FLD_INTER    = 4'ha,
		FLD_ERR_FLAG = 4'hb,
		FLD_ERR_DEL  = 4'hc,
		FLD_OVL_FLAG = 4'hd,
		FLD_OVL_DEL  = 4'he
	} cfc_fld_t;

	typedef enum logic [2:0] {
		S_DIS    = 3'h0,
		S_SYNC   = 3'h1,
		S_RUN    = 3'h2,
		S_LPWAIT = 3'h3,
		S_SLEEP  = 3'h4
	} cfc_st_t;

	// one sample point of the bit stream
	typedef struct packed {
		logic        tick;
		cfc_fld_t    fld;
		logic [3:0]  idx;
		logic        last;
		logic        stuff_bit;
		logic        tx_act;
		logic        tx_bit;
	} cfc_bit_t;

	typedef struct packed {
		logic tx_ok;
		logic rx_ok;
		logic delivered;
		logic tx_pending;
	} cfc_evt_t;

	localparam logic [3:0]  OFF_MODE    = 4'h0;
	localparam logic [3:0]  OFF_MASK    = 4'h4;
	localparam logic [3:0]  OFF_STATUS  = 4'h8;
	localparam logic [3:0]  OFF_ERRCNT  = 4'hc;

	localparam int          MD_EN       = 0;
	localparam int          MD_LPM      = 1;
	localparam int          MD_OVL      = 2;

	localparam int          ST_ACTIVE   = 0;
	localparam int          ST_WARN     = 1;
	localparam int          ST_PASSIVE  = 2;
	localparam int          ST_BUS_OFF_STATUS     = 3;
	localparam int          ST_SLEEP    = 4;
	localparam int          ST_WAKE     = 5;
	localparam int          ST_ERR_LSB  = 8;
	localparam int          ERR_N       = 5;
	localparam int          ERR_ACK     = 0;
	localparam int          ERR_FORM    = 1;
	localparam int          ERR_CRC     = 2;
	localparam int          ERR_STUFF   = 3;
	localparam int          ERR_BIT     = 4;
	localparam int          EC_TEC_LSB  = 16;
	localparam logic [31:0] MASK_USED   = 32'h00001f3f;

	localparam logic [8:0]  WARN_LIMIT  = 9'h060;
	localparam logic [8:0]  PASS_LIMIT  = 9'h07f;
	localparam logic [8:0]  BUS_OFF_STATUS_LIMIT  = 9'h0ff;
	localparam logic [8:0]  TEC_INC     = 9'h008;
	localparam logic [7:0]  REC_INC     = 8'h01;
	localparam logic [3:0]  RUN_LEN     = 4'hb;
	localparam logic [7:0]  BUS_OFF_STATUS_RUNS   = 8'h80;
	localparam logic [2:0]  STUFF_LIMIT = 3'h6;
	localparam logic [3:0]  INTER_REACT = 4'h2;
	localparam logic [14:0] CRC_POLY    = 15'h4599;

endpackage : cfc_pkg

// ==== cfc_bus_model.sv ====
// Purpose: bus seen by the node, wired-and of this node and the other nodes
// Assumes: 0 is dominant, the line idles recessive through the transceiver
// Notes:   other_dom is what the other nodes drive, as the bench commands
`timescale 1ns/1ps
`default_nettype none
module cfc_bus_model (
	input  wire logic drive_en,
	input  wire logic tx_act,
	input  wire logic tx_bit,
	input  wire logic other_dom,
	output logic      canrx
);
	wire node_dom = drive_en & tx_act & ~tx_bit;
	// other nodes acknowledge by pulling the slot dominant
	assign canrx = ~(node_dom | other_dom);
endmodule : cfc_bus_model
`default_nettype wire

// ==== can_fault_confinement_and_sleep_bench.sv ====
// Purpose: scenario bench of the fault confinement and sleep block
// Assumes: one sample tick every five cycles, ce held high
// Notes:   bus level settles three cycles before each tick
`timescale 1ns/1ps
`default_nettype none
module can_fault_confinement_and_sleep_bench;
	logic              mclk, nrst, ce, canrx, wr_s, rd_s, other_dom;
	cfc_pkg::cfc_bit_t b;
	cfc_pkg::cfc_evt_t ev;
	logic [3:0]        addr;
	logic [31:0]       wdata, rdata, v;
	logic              efr, efp, overload_request_enable, sus, txe, rxe, mbe, bde, irq, ofr;
	logic [14:0]       crc;
	int                n_mismatch, comparisons;

	cfc_fault_confine cfc_fault_confine_inst (.mclk(mclk), .nrst(nrst), .ce(ce),
		.canrx(canrx), .bit_i(b), .evt_i(ev), .addr(addr), .wdata(wdata), .wr(wr_s),
		.rd(rd_s), .rdata(rdata), .err_frame_req(efr), .err_flag_passive(efp),
		.ovl_frame_req(ofr), .tx_suspend(sus), .tx_enable(txe), .rx_enable(rxe),
		.mbox_enable(mbe), .bus_drive_en(bde), .crc_value(crc), .irq(irq));
	cfc_bus_model cfc_bus_model_inst (.drive_en(bde), .tx_act(b.tx_act),
		.tx_bit(b.tx_bit), .other_dom(other_dom), .canrx(canrx));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge mclk);
		wr_s <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask : rd

	// one bit: field, index, transmitter, driven level, others dominant, tx_ok
	task automatic sbit(input cfc_pkg::cfc_fld_t f, input logic [3:0] i,
		input logic ta, input logic tb, input logic od, input logic ok);
		@(posedge mclk);
		b <= '{tick:1'b0, fld:f, idx:i, last:1'b0, stuff_bit:1'b0, tx_act:ta, tx_bit:tb};
		other_dom <= od;
		repeat (3) @(posedge mclk);
		b.tick <= 1'b1;
		ev.tx_ok <= ok;
		@(posedge mclk);
		b.tick <= 1'b0;
		ev.tx_ok <= 1'b0;
		#1 overload_request_enable = ofr;
	endtask : sbit

	task automatic recs(input int n);
		repeat (n) sbit(cfc_pkg::FLD_IDLE, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0);
	endtask : recs

	task automatic ack_err(input int n);
		repeat (n) sbit(cfc_pkg::FLD_ACK_SLOT, 4'h0, 1'b1, 1'b1, 1'b0, 1'b0);
	endtask : ack_err

	task automatic t_reset;
		rd(cfc_pkg::OFF_STATUS, v);
		chk("status after reset", v & 32'h3f, 32'h01);
		rd(4'h2, v);
		chk("unmapped read", v, 32'h0);
		chk("irq after reset", irq, 1'b0);
	endtask : t_reset

	// wake is only cleared by sleep, so a re-enable keeps it set
	task automatic t_sync(input logic early_wake);
		wr(cfc_pkg::OFF_MODE, 32'h1);
		recs(10);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("wake early", v[5], early_wake);
		chk("tx held before sync", txe, 1'b0);
		recs(1);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("wake after 11", v[5:4], 2'b10);
		chk("tx enabled", txe, 1'b1);
		chk("rx enabled", rxe, 1'b1);
	endtask : t_sync

	task automatic t_errors;
		ack_err(1);
		chk("ack error frame", efr, 1'b1);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("ack flag", v[12:8], 5'h01);
		sbit(cfc_pkg::FLD_ACK_SLOT, 4'h0, 1'b1, 1'b1, 1'b1, 1'b1);
		rd(cfc_pkg::OFF_ERRCNT, v);
		chk("tec after ok", v, 32'h00070000);
		wr(cfc_pkg::OFF_MASK, 32'h2);
		chk("irq masked cause", irq, 1'b0);
		ack_err(12);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("warn state", v[3:0], 4'h3);
		chk("warn irq", irq, 1'b1);
		ack_err(4);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("passive state", {v[3:2], v[0]}, 3'b010);
		chk("passive flag", efp, 1'b1);
		sbit(cfc_pkg::FLD_ACK_SLOT, 4'h0, 1'b1, 1'b1, 1'b1, 1'b1);
		chk("suspend", sus, 1'b1);
		ack_err(16);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("bus off state", {v[3:2], v[0]}, 3'b110);
		chk("bus off silent", bde, 1'b0);
	endtask : t_errors

	task automatic t_bus_off;
		recs(1407);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("still bus off", v[3], 1'b1);
		recs(1);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("bus off left", {v[3:2], v[0]}, 3'b001);
		rd(cfc_pkg::OFF_ERRCNT, v);
		chk("counters cleared", v, 32'h0);
	endtask : t_bus_off

	task automatic t_frames;
		sbit(cfc_pkg::FLD_CRC_DEL, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("form flag", v[12:8], 5'h02);
		sbit(cfc_pkg::FLD_INTER, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0);
		chk("reactive overload", overload_request_enable, 1'b1);
		rd(cfc_pkg::OFF_ERRCNT, v);
		chk("overload keeps counts", v, 32'h1);
		sbit(cfc_pkg::FLD_SOF, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0);
		for (int i = 0; i < 5; i++)
			sbit(cfc_pkg::FLD_ARB, 4'(i), 1'b0, 1'b1, 1'b1, 1'b0);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("stuff flag", v[12:8], 5'h08);
		sbit(cfc_pkg::FLD_SOF, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
		sbit(cfc_pkg::FLD_DATA, 4'h0, 1'b1, 1'b1, 1'b1, 1'b0);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("bit flag", v[12:8], 5'h10);
		rd(cfc_pkg::OFF_ERRCNT, v);
		chk("mixed counts", v, 32'h00080002);
	endtask : t_frames

	task automatic t_crc;
		sbit(cfc_pkg::FLD_SOF, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0);
		@(posedge mclk);
		b <= '{tick:1'b0, fld:cfc_pkg::FLD_CRC, idx:4'he, last:1'b1, stuff_bit:1'b0,
			tx_act:1'b0, tx_bit:1'b1};
		other_dom <= 1'b0;
		repeat (3) @(posedge mclk);
		b.tick <= 1'b1;
		@(posedge mclk);
		b.tick <= 1'b0;
		#1 chk("crc error frame", efr, 1'b1);
		chk("crc value", crc, cfc_pkg::CRC_POLY);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("crc flag", v[12:8], 5'h04);
	endtask : t_crc

	task automatic t_reenable;
		ack_err(1);
		wr(cfc_pkg::OFF_MODE, 32'h0);
		wr(cfc_pkg::OFF_MODE, 32'h1);
		rd(cfc_pkg::OFF_ERRCNT, v);
		chk("enable clears counts", v, 32'h0);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("enable clears flags", v[12:8], 5'h0);
		t_sync(1'b1);
	endtask : t_reenable

	task automatic t_sleep;
		@(posedge mclk);
		ev.tx_pending <= 1'b1;
		wr(cfc_pkg::OFF_MODE, 32'h3);
		recs(2);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("sleep held by pending", v[4], 1'b0);
		@(posedge mclk);
		ev.tx_pending <= 1'b0;
		recs(1);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("sleep entered", v[5:4], 2'b01);
		chk("mailboxes off", mbe, 1'b0);
		chk("tx off", txe, 1'b0);
		chk("rx off", rxe, 1'b0);
		ack_err(1);
		rd(cfc_pkg::OFF_ERRCNT, v);
		chk("counts frozen", v, 32'h0);
		wr(cfc_pkg::OFF_MODE, 32'h1);
		recs(11);
		rd(cfc_pkg::OFF_STATUS, v);
		chk("woken", v[5:4], 2'b10);
	endtask : t_sleep

	task automatic t_ovl_req;
		int k;
		wr(cfc_pkg::OFF_MODE, 32'h5);
		@(posedge mclk);
		ev.delivered <= 1'b1;
		@(posedge mclk);
		ev.delivered <= 1'b0;
		#1 k = 0;
		while (ofr !== 1'b1 && k < 4) begin
			@(posedge mclk);
			#1 k++;
		end
		chk("request overload", ofr, 1'b1);
	endtask : t_ovl_req

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		wr_s = 1'b0;
		rd_s = 1'b0;
		other_dom = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		b = '0;
		ev = '0;
		n_mismatch = 0;
		comparisons = 0;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(posedge mclk);
		t_reset();
		t_sync(1'b0);
		t_errors();
		t_bus_off();
		t_frames();
		t_crc();
		t_reenable();
		t_sleep();
		t_ovl_req();
		conclude();
	end
endmodule : can_fault_confinement_and_sleep_bench
`default_nettype wire
